// *** hdl/synth_serial_control_defines.svh ***
/*
  Constants of the synthesizer serial control block: pointer codes, field
  positions, preset values and timing counts. Assumes a 50 ns system clock.
*/
`ifndef SYNTH_SERIAL_CONTROL_DEFINES_SVH
`define SYNTH_SERIAL_CONTROL_DEFINES_SVH

`define SLAVE_ADDR_HI    6'h31
`define PTR_REF          2'h0
`define PTR_LOOP         2'h1
`define PTR_MID          2'h2
`define PTR_LOW          2'h3
`define SUB_MASK_BIT     4
`define SUB_STEP_BIT     3
`define REF_PD_BIT       7
`define REF_PUMP_BIT     5
`define LOOP_FIXED       3'h5
`define LOOP_PHI_BIT     4
`define LOOP_SWB_BIT     3
`define LOOP_SWA_BIT     2
`define REF_SETUP_RST    8'h0e
`define LOOP_SETUP_RST   8'ha5
`define RATIO_MID_RST    8'h38
`define RATIO_LOW_RST    8'h80
`define RATIO_FLOOR      18'h00800
`define MAX_BURST        3'h4
`define CLK_PERIOD_NS    50
`define PHASE_ERR_NS     200
`define PHASE_ERR_CYC    ((`PHASE_ERR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RELOCK_REF_CYC   6

`endif

// *** hdl/synth_serial_control_pkg.sv ***
/*
  Types of the synthesizer serial control block.
  Assumes nothing of its surroundings.
*/
package synth_serial_control_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_SUB, ST_WDATA, ST_RDATA, ST_RACK, ST_WAIT
  } serial_state_e;
endpackage

// *** hdl/synth_serial_control.sv ***
/*
  Serial control section of a channel synthesizer: two-wire bus slave,
  four setup registers, status byte, latched alarm, dividers, phase
  comparator and unlock detector.
  Assumes all pins are asynchronous to clock_i; open-drain pins are
  resolved outside from the output enables.
*/
// What this block does
// - write is address, subaddress, one to four bytes
// - first byte at pointer, autostep advances pointer
// - autostep off keeps pointer fixed all transfer
// - slave address upper six bits are 110001
// - select bit expected is inverse of pin
// - subaddress holds mask, autostep, two-bit pointer
// - mask flag set suppresses the alarm output
// - pointer selects reference, loop, middle, low register
// - register bit layout as defined for setup
// - registers preset to 0e, a5, 38, 80
// - power-down bit one idles the synthesizer
// - pump current select: one is 1 mA
// - ratio is 13-bit main plus 5-bit swallow
// - reference code selects one of sixteen ratios
// - comparator up/down by frequency, swapped by invert
// - unlock or supply dip latches alarm low
// - alarm released only after status read completes
// - status byte bits 4, 2, 1, 0 defined
// - status read is address then one byte
// - new ratio loads after low byte, at divider
// - ratio below 2048 gets 2048 added
// - unlock over 200 ns, clears after 6 reference cycles
`timescale 1ns/10ps
`default_nettype none
`include "synth_serial_control_defines.svh"

module synth_serial_control
  import synth_serial_control_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        srst_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output var  logic        sda_o,
  output var  logic        sda_oe_o,
  input  wire logic        addr_select_pin_i,
  input  wire logic        osc_i,
  input  wire logic        rf_i,
  input  wire logic        supply_dip_i,
  output var  logic        alarm_out_pin_o,
  output var  logic        alarm_out_pin_oe_o,
  output var  logic        switch_out_a_o,
  output var  logic        switch_out_b_o,
  output var  logic        pump_up_o,
  output var  logic        pump_down_o,
  output var  logic        pump_current_sel_o,
  output var  logic        power_down_o,
  output var  logic [12:0] main_count_o,
  output var  logic [4:0]  swallow_count_o
);

  function automatic logic [10:0] ref_ratio(input logic [3:0] code);
    unique case (code)
      4'h0: ref_ratio = 11'd128;
      4'h1: ref_ratio = 11'd160;
      4'h2: ref_ratio = 11'd192;
      4'h3: ref_ratio = 11'd240;
      4'h4: ref_ratio = 11'd256;
      4'h5: ref_ratio = 11'd320;
      4'h6: ref_ratio = 11'd384;
      4'h7: ref_ratio = 11'd480;
      4'h8: ref_ratio = 11'd512;
      4'h9: ref_ratio = 11'd640;
      4'ha: ref_ratio = 11'd768;
      4'hb: ref_ratio = 11'd960;
      4'hc: ref_ratio = 11'd1024;
      4'hd: ref_ratio = 11'd1280;
      4'he: ref_ratio = 11'd1536;
      4'hf: ref_ratio = 11'd1920;
    endcase
  endfunction

  function automatic logic [17:0] floor_ratio(input logic [17:0] x);
    floor_ratio = (x < `RATIO_FLOOR) ? x + `RATIO_FLOOR : x;
  endfunction

  // two-flop synchronisers, then one more stage for edge finding
  logic [5:0]    sync1;
  logic [5:0]    sync2;
  logic [5:0]    sync3;
  logic          scl_s, sda_s, sel_s, dip_s;
  logic          scl_rise, scl_fall, bus_start, bus_stop, osc_edge, rf_edge;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      // idle pin levels: bus lines high, the rest low, so no false event
      sync1 <= 6'h03;
      sync2 <= 6'h03;
      sync3 <= 6'h03;
    end else begin
      sync1 <= {supply_dip_i, rf_i, osc_i, addr_select_pin_i, sda_i, scl_i};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  assign scl_s     = sync2[0];
  assign sda_s     = sync2[1];
  assign sel_s     = sync2[2];
  assign dip_s     = sync2[5];
  assign scl_rise  = scl_s & ~sync3[0];
  assign scl_fall  = ~scl_s & sync3[0];
  assign bus_start = scl_s & sync3[0] & sync3[1] & ~sda_s;
  assign bus_stop  = scl_s & sync3[0] & ~sync3[1] & sda_s;
  assign osc_edge  = sync2[3] & ~sync3[3];
  assign rf_edge   = sync2[4] & ~sync3[4];

  // registers and status
  logic [7:0]    ref_setup_reg, loop_setup_reg, ratio_mid_reg, ratio_low_reg;
  logic [1:0]    ptr;
  logic          pointer_autostep, alarm_mask;
  logic          momentary_unlock, latched_unlock, latched_supply_dip;
  logic [7:0]    lock_status_reg;

  assign lock_status_reg = {3'h0, momentary_unlock, 1'b0, latched_unlock,
                            latched_supply_dip, alarm_mask};

  // serial slave
  serial_state_e state, after_ack;
  logic [3:0]    bit_cnt;
  logic [7:0]    shreg;
  logic [2:0]    byte_cnt;
  logic          ack_drive, sub_stb, wr_stb, read_done;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state     <= ST_IDLE;
      after_ack <= ST_IDLE;
      bit_cnt   <= 4'h0;
      shreg     <= 8'h00;
      byte_cnt  <= 3'h0;
      ack_drive <= 1'b0;
      sda_oe_o  <= 1'b0;
      sub_stb   <= 1'b0;
      wr_stb    <= 1'b0;
      read_done <= 1'b0;
    end else begin
      sub_stb   <= 1'b0;
      wr_stb    <= 1'b0;
      read_done <= 1'b0;
      if (bus_start) begin
        state     <= ST_ADDR;
        bit_cnt   <= 4'h0;
        ack_drive <= 1'b0;
        sda_oe_o  <= 1'b0;
      end else if (bus_stop) begin
        state     <= ST_IDLE;
        ack_drive <= 1'b0;
        sda_oe_o  <= 1'b0;
      end else if (scl_rise) begin
        if (state == ST_RDATA) begin
          bit_cnt <= bit_cnt + 4'h1;
        end else if (state == ST_RACK) begin
          read_done <= 1'b1;
          state     <= ST_WAIT;
        end else if ((state == ST_ADDR || state == ST_SUB || state == ST_WDATA)
                     && !ack_drive && bit_cnt < 4'h8) begin
          shreg   <= {shreg[6:0], sda_s};
          bit_cnt <= bit_cnt + 4'h1;
        end
      end else if (scl_fall) begin
        if (ack_drive) begin
          ack_drive <= 1'b0;
          bit_cnt   <= 4'h0;
          state     <= after_ack;
          if (after_ack == ST_RDATA) begin
            shreg    <= lock_status_reg;
            sda_oe_o <= ~lock_status_reg[7];
          end else begin
            sda_oe_o <= 1'b0;
          end
        end else if (state == ST_RDATA) begin
          if (bit_cnt == 4'h8) begin
            sda_oe_o <= 1'b0;
            state    <= ST_RACK;
          end else begin
            shreg    <= {shreg[6:0], 1'b0};
            sda_oe_o <= ~shreg[6];
          end
        end else if (bit_cnt == 4'h8) begin
          unique case (state)
            ST_ADDR: begin
              if (shreg[7:1] == {`SLAVE_ADDR_HI, ~sel_s}) begin
                ack_drive <= 1'b1;
                sda_oe_o  <= 1'b1;
                after_ack <= shreg[0] ? ST_RDATA : ST_SUB;
              end else begin
                state <= ST_WAIT;
              end
            end
            ST_SUB: begin
              sub_stb   <= 1'b1;
              byte_cnt  <= 3'h0;
              ack_drive <= 1'b1;
              sda_oe_o  <= 1'b1;
              after_ack <= ST_WDATA;
            end
            ST_WDATA: begin
              if (byte_cnt < `MAX_BURST) begin
                wr_stb    <= 1'b1;
                byte_cnt  <= byte_cnt + 3'h1;
                ack_drive <= 1'b1;
                sda_oe_o  <= 1'b1;
                after_ack <= ST_WDATA;
              end else begin
                state <= ST_WAIT;
              end
            end
            default: state <= ST_WAIT;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      sda_o           <= 1'b0;
      alarm_out_pin_o <= 1'b0;
    end else begin
      sda_o           <= 1'b0;
      alarm_out_pin_o <= 1'b0;
    end
  end

  // subaddress flags and pointer
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ptr              <= `PTR_REF;
      pointer_autostep <= 1'b0;
      alarm_mask       <= 1'b0;
    end else if (sub_stb) begin
      alarm_mask       <= shreg[`SUB_MASK_BIT];
      pointer_autostep <= shreg[`SUB_STEP_BIT];
      ptr              <= shreg[1:0];
    end else if (wr_stb && pointer_autostep) begin
      ptr <= ptr + 2'h1;
    end
  end

  // setup registers
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ref_setup_reg  <= `REF_SETUP_RST;
      loop_setup_reg <= `LOOP_SETUP_RST;
      ratio_mid_reg  <= `RATIO_MID_RST;
      ratio_low_reg  <= `RATIO_LOW_RST;
    end else if (wr_stb) begin
      unique case (ptr)
        `PTR_REF:  ref_setup_reg  <= shreg & 8'haf;
        `PTR_LOOP: loop_setup_reg <= {`LOOP_FIXED, shreg[4:0]};
        `PTR_MID:  ratio_mid_reg  <= shreg;
        `PTR_LOW:  ratio_low_reg  <= shreg;
      endcase
    end
  end

  // reference divider and main divider with ratio hand-over
  logic [10:0]   ref_cnt;
  logic [17:0]   var_cnt, active_ratio;
  logic          ref_tick, var_tick, ratio_pending, pd;
  localparam logic [17:0] preset_ratio = {2'(`LOOP_SETUP_RST), `RATIO_MID_RST, `RATIO_LOW_RST};

  assign pd       = ref_setup_reg[`REF_PD_BIT];
  assign ref_tick = !pd && osc_edge && ref_cnt == ref_ratio(ref_setup_reg[3:0]) - 11'd1;
  assign var_tick = !pd && rf_edge && var_cnt == active_ratio - 18'd1;

  always_ff @(posedge clock_i) begin
    if (srst_i || pd) begin
      ref_cnt <= 11'h000;
    end else if (osc_edge) begin
      ref_cnt <= ref_tick ? 11'h000 : ref_cnt + 11'h001;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ratio_pending <= 1'b0;
    end else if (wr_stb && ptr == `PTR_LOW) begin
      ratio_pending <= 1'b1;
    end else if (var_tick) begin
      ratio_pending <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      var_cnt      <= 18'h00000;
      active_ratio <= floor_ratio(preset_ratio);
    end else if (pd) begin
      var_cnt <= 18'h00000;
    end else if (rf_edge) begin
      var_cnt <= var_tick ? 18'h00000 : var_cnt + 18'h00001;
      if (var_tick && ratio_pending) begin
        active_ratio <= floor_ratio({loop_setup_reg[1:0], ratio_mid_reg, ratio_low_reg});
      end
    end
  end

  // phase comparator and unlock detector
  logic          up_ff, dn_ff, err_big;
  logic [3:0]    err_cnt;
  logic [2:0]    good_cnt;

  always_ff @(posedge clock_i) begin
    if (srst_i || pd || (up_ff && dn_ff)) begin
      up_ff <= 1'b0;
      dn_ff <= 1'b0;
    end else begin
      up_ff <= up_ff | ref_tick;
      dn_ff <= dn_ff | var_tick;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      err_cnt          <= 4'h0;
      err_big          <= 1'b0;
      good_cnt         <= 3'h0;
      momentary_unlock <= 1'b0;
    end else begin
      err_cnt <= (up_ff ^ dn_ff) ? err_cnt + {3'h0, err_cnt != 4'hf} : 4'h0;
      if (err_cnt >= 4'(`PHASE_ERR_CYC)) begin
        err_big          <= 1'b1;
        momentary_unlock <= 1'b1;
        good_cnt         <= 3'h0;
      end else if (ref_tick) begin
        err_big <= 1'b0;
        if (err_big) begin
          good_cnt <= 3'h0;
        end else if (good_cnt == 3'(`RELOCK_REF_CYC - 1)) begin
          good_cnt         <= 3'h0;
          momentary_unlock <= 1'b0;
        end else begin
          good_cnt <= good_cnt + 3'h1;
        end
      end
    end
  end

  // latched status: a new event wins over the read clear
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      latched_unlock     <= 1'b0;
      latched_supply_dip <= 1'b0;
    end else begin
      latched_unlock     <= momentary_unlock | (latched_unlock & ~read_done);
      latched_supply_dip <= dip_s | (latched_supply_dip & ~read_done);
    end
  end

  // pin outputs
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      alarm_out_pin_oe_o <= 1'b0;
      switch_out_a_o     <= 1'b0;
      switch_out_b_o     <= 1'b0;
      pump_up_o          <= 1'b0;
      pump_down_o        <= 1'b0;
      pump_current_sel_o <= 1'b0;
      power_down_o       <= 1'b0;
      main_count_o       <= 13'h0000;
      swallow_count_o    <= 5'h00;
    end else begin
      alarm_out_pin_oe_o <= (latched_unlock | latched_supply_dip) & ~alarm_mask;
      switch_out_a_o     <= loop_setup_reg[`LOOP_SWA_BIT] & ~momentary_unlock;
      switch_out_b_o     <= loop_setup_reg[`LOOP_SWB_BIT];
      pump_up_o   <= loop_setup_reg[`LOOP_PHI_BIT] ? dn_ff & ~up_ff : up_ff & ~dn_ff;
      pump_down_o <= loop_setup_reg[`LOOP_PHI_BIT] ? up_ff & ~dn_ff : dn_ff & ~up_ff;
      pump_current_sel_o <= ref_setup_reg[`REF_PUMP_BIT];
      power_down_o       <= pd;
      main_count_o       <= active_ratio[17:5];
      swallow_count_o    <= active_ratio[4:0];
    end
  end

  // checks
  sequence s_write_byte;
    wr_stb;
  endsequence

  sequence s_unlock_seen;
    momentary_unlock && !alarm_mask;
  endsequence

  a_ptr_fixed_hold: assert property (@(posedge clock_i) disable iff (srst_i)
    s_write_byte ##0 !pointer_autostep |=> $stable(ptr))
    else $error("pointer moved with autostep off");

  a_ptr_step_once: assert property (@(posedge clock_i) disable iff (srst_i)
    s_write_byte ##0 pointer_autostep |=> ptr == $past(ptr) + 2'h1)
    else $error("pointer did not step by one");

  a_alarm_on_unlock: assert property (@(posedge clock_i) disable iff (srst_i)
    s_unlock_seen ##1 !alarm_mask |-> ##1 alarm_out_pin_oe_o)
    else $error("alarm not driven after unlock");

  a_mask_blocks_alarm: assert property (@(posedge clock_i) disable iff (srst_i)
    alarm_out_pin_oe_o |-> !$past(alarm_mask))
    else $error("alarm driven while masked");

  a_read_clears_latch: assert property (@(posedge clock_i) disable iff (srst_i)
    read_done && !momentary_unlock && !dip_s |=> !latched_unlock && !latched_supply_dip)
    else $error("latched bits survived status read");

  a_switch_a_forced: assert property (@(posedge clock_i) disable iff (srst_i)
    momentary_unlock |=> !switch_out_a_o)
    else $error("switch A high during unlock");

  a_pump_exclusive: assert property (@(posedge clock_i) disable iff (srst_i)
    !(pump_up_o && pump_down_o))
    else $error("up and down together");

  a_pump_up_dir: assert property (@(posedge clock_i) disable iff (srst_i)
    up_ff && !dn_ff && !loop_setup_reg[`LOOP_PHI_BIT] |=> pump_up_o)
    else $error("up not driven for leading reference");

  a_ratio_floor_kept: assert property (@(posedge clock_i) disable iff (srst_i)
    active_ratio >= `RATIO_FLOOR)
    else $error("main ratio below floor");

  a_preset_values: assert property (@(posedge clock_i)
    $past(srst_i) |-> ref_setup_reg == `REF_SETUP_RST && loop_setup_reg == `LOOP_SETUP_RST
      && ratio_mid_reg == `RATIO_MID_RST && ratio_low_reg == `RATIO_LOW_RST)
    else $error("preset values wrong after reset");

  a_loop_fixed_bits: assert property (@(posedge clock_i) disable iff (srst_i)
    loop_setup_reg[7:5] == `LOOP_FIXED)
    else $error("loop setup fixed bits changed");

endmodule
`default_nettype wire

// *** verification/synth_i2c_master.sv ***
/*
  Two-wire bus master model: start, stop, byte and frame tasks.
  Assumes a pulled-up data line resolved by the bench, 4-clock SCL phases.
*/
`timescale 1ns/10ps
`default_nettype none
`include "synth_serial_control_defines.svh"

module synth_i2c_master (
  input  wire logic clock_i,
  input  wire logic sda_line_i,
  output var  logic scl_o,
  output var  logic sda_pull_o
);
  initial begin
    scl_o      = 1'b1;
    sda_pull_o = 1'b0;
  end

  task automatic ticks(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  // data changes mid low phase, sampled at end of high phase
  task automatic bit_cycle(input logic pull, output logic seen);
    scl_o <= 1'b0;
    ticks(2);
    sda_pull_o <= pull;
    ticks(2);
    scl_o <= 1'b1;
    ticks(4);
    seen = sda_line_i;
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cycle(~b[i], s);
    bit_cycle(1'b0, s);
    ack = ~s;
  endtask

  task automatic get_byte(input logic give_ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cycle(1'b0, b[i]);
    bit_cycle(give_ack, s);
  endtask

  task automatic bus_start();
    ticks(4);
    sda_pull_o <= 1'b1;
    ticks(4);
  endtask

  task automatic bus_stop();
    scl_o <= 1'b0;
    ticks(2);
    sda_pull_o <= 1'b1;
    ticks(2);
    scl_o <= 1'b1;
    ticks(4);
    sda_pull_o <= 1'b0;
    ticks(4);
  endtask

  task automatic write_frame(input logic sel, input logic [7:0] sub, input logic [7:0] d [5],
                             input int n, output logic [6:0] acks);
    acks = '0;
    bus_start();
    send_byte({`SLAVE_ADDR_HI, sel, 1'b0}, acks[0]);
    send_byte(sub, acks[1]);
    for (int i = 0; i < n; i++) send_byte(d[i], acks[i + 2]);
    bus_stop();
  endtask

  task automatic read_frame(input logic sel, output logic ack, output logic [7:0] st);
    bus_start();
    send_byte({`SLAVE_ADDR_HI, sel, 1'b1}, ack);
    get_byte(1'b0, st);
    bus_stop();
  endtask
endmodule
`default_nettype wire

// *** verification/synth_serial_control_tb_top.sv ***
/*
  Self-checking bench for the synthesizer serial control block.
  Assumes the bus master model and the design's defines header.
*/
`timescale 1ns/10ps
`default_nettype none
`include "synth_serial_control_defines.svh"

module synth_serial_control_tb_top;
  logic        clock_i;
  logic        srst_i;
  logic        scl;
  logic        sda_pull;
  logic        addr_select_pin_i;
  logic        rf_i;
  logic        supply_dip_i;
  logic        osc_run;
  logic [1:0]  osc_ph = 2'h0;
  wire         osc_i = osc_ph[1];
  wire         sda_line;
  logic        sda_o, sda_oe, alarm_o, alarm_oe, swa, swb, up, dn, isel, pd;
  logic [12:0] main_cnt;
  logic [4:0]  swal;
  int          n_errors = 0;
  int          samples_checked = 0;
  logic [7:0]  exp_reg [4];
  logic        exp_unl;
  logic [6:0]  acks;
  logic [7:0]  st;
  logic        ack;
  logic [7:0]  d [5];

  assign sda_line = !(sda_pull || (sda_oe && !sda_o));
  always #25 clock_i = ~clock_i;
  // reference edges every 4 clocks while enabled
  always @(posedge clock_i) if (osc_run) osc_ph <= osc_ph + 2'h1;

  synth_serial_control dut_u (
    .clock_i(clock_i), .srst_i(srst_i), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .addr_select_pin_i(addr_select_pin_i), .osc_i(osc_i), .rf_i(rf_i),
    .supply_dip_i(supply_dip_i), .alarm_out_pin_o(alarm_o), .alarm_out_pin_oe_o(alarm_oe),
    .switch_out_a_o(swa), .switch_out_b_o(swb), .pump_up_o(up), .pump_down_o(dn),
    .pump_current_sel_o(isel), .power_down_o(pd), .main_count_o(main_cnt),
    .swallow_count_o(swal));

  synth_i2c_master master_u (
    .clock_i(clock_i), .sda_line_i(sda_line), .scl_o(scl), .sda_pull_o(sda_pull));

  task automatic ticks(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  task automatic tally_and_finish();
    $display("errors %0d, comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [17:0] exp, input logic [17:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic wait_for(input logic want_dn, input string what);
    int k;
    for (k = 0; k < 3000; k++) begin
      if ((want_dn ? dn : up) === 1'b1) break;
      ticks(1);
    end
    if (k == 3000) begin
      n_errors++;
      $display("wrong value %s: expected 1, seen timeout", what);
      tally_and_finish();
    end
  endtask

  task automatic check_outs();
    ticks(3);
    check("power down", 18'(exp_reg[0][7]), 18'(pd));
    check("pump current", 18'(exp_reg[0][5]), 18'(isel));
    check("switch b", 18'(exp_reg[1][3]), 18'(swb));
    check("switch a", 18'(exp_reg[1][2] & ~exp_unl), 18'(swa));
    check("main ratio held", 18'd2500, 18'(main_cnt));
    check("swallow held", 18'd0, 18'(swal));
    check("alarm drive", 18'h0, 18'(alarm_o));
  endtask

  task automatic wr(input logic [7:0] sub, input int n);
    logic [1:0] p;
    p = sub[1:0];
    master_u.write_frame(~addr_select_pin_i, sub, d, n, acks);
    for (int i = 0; i < n && i < 4; i++) begin
      exp_reg[p] = d[i];
      if (sub[`SUB_STEP_BIT]) p = p + 2'h1;
    end
    check("acks", 18'(((7'h01 << (n + 2)) - 7'h01) & 7'h3f), 18'(acks));
    check_outs();
  endtask

  task automatic rd(input logic [7:0] exp_st);
    master_u.read_frame(~addr_select_pin_i, ack, st);
    check("read ack", 18'h1, 18'(ack));
    check("status", 18'(exp_st), 18'(st));
  endtask

  task automatic dip_pulse();
    supply_dip_i <= 1'b1;
    ticks(10);
    supply_dip_i <= 1'b0;
    ticks(5);
  endtask

  task automatic rand_data();
    for (int i = 0; i < 5; i++) d[i] = 8'($urandom);
  endtask

  initial begin
    clock_i = 1'b0;
    srst_i = 1'b1;
    addr_select_pin_i = 1'b0;
    supply_dip_i = 1'b0;
    rf_i = 1'b0;
    osc_run = 1'b0;
    exp_unl = 1'b0;
    void'($urandom(42982));
    exp_reg = '{`REF_SETUP_RST, `LOOP_SETUP_RST, `RATIO_MID_RST, `RATIO_LOW_RST};
    repeat (12) @(posedge clock_i);
    srst_i <= 1'b0;
    addr_select_pin_i <= 1'($urandom);
    ticks(2);
    check("main ratio", 18'd2500, 18'(main_cnt));
    check("swallow", 18'd0, 18'(swal));
    check_outs();
    // burst with power-down set, then more traffic while idle
    rand_data();
    d[0] = d[0] | 8'h80;
    wr(8'h08, 2);
    rand_data();
    wr(8'h01, 2);
    // ignored subaddress bits set, pointer wraps from low to ref
    rand_data();
    wr(8'hef, 2);
    rand_data();
    wr(8'h00, 5);
    // foreign select bit, then the other pin level
    rand_data();
    master_u.write_frame(addr_select_pin_i, 8'h08, d, 2, acks);
    check("foreign acks", 18'h0, 18'(acks));
    check_outs();
    addr_select_pin_i <= ~addr_select_pin_i;
    // new pin level must land before the address is formed from it
    ticks(1);
    rand_data();
    wr(8'h09, 1);
    // supply dip alarm, held through writes, released by status read
    wr(8'h01, 1);
    dip_pulse();
    check("alarm", 18'h1, 18'(alarm_oe));
    rand_data();
    wr(8'h01, 1);
    check("alarm held", 18'h1, 18'(alarm_oe));
    rd(8'h02);
    ticks(2);
    check("alarm released", 18'h0, 18'(alarm_oe));
    rd(8'h00);
    rand_data();
    wr(8'h11, 1);
    dip_pulse();
    check("masked alarm", 18'h0, 18'(alarm_oe));
    rd(8'h03);
    // reset in mid-run brings the presets back
    srst_i <= 1'b1;
    ticks(3);
    srst_i <= 1'b0;
    exp_reg = '{`REF_SETUP_RST, `LOOP_SETUP_RST, `RATIO_MID_RST, `RATIO_LOW_RST};
    check_outs();
    // loss of lock: reference ticks with no divided input
    d = '{8'h00, 8'h04, 8'h00, 8'h00, 8'h00};
    wr(8'h08, 2);
    osc_run <= 1'b1;
    wait_for(1'b0, "pump up");
    check("pump down", 18'h0, 18'(dn));
    exp_unl = 1'b1;
    ticks(20);
    check_outs();
    check("unlock alarm", 18'h1, 18'(alarm_oe));
    rd(8'h14);
    d[0] = 8'h14;
    wr(8'h01, 1);
    wait_for(1'b1, "pump down");
    check("pump up", 18'h0, 18'(up));
    tally_and_finish();
  end
endmodule
`default_nettype wire
